//--- design/sgac_top.sv
// side-channel pins, their registers and the audio input lane control
`timescale 1ns/1ps
module sgac_top (
  input wire logic SYS_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic LINK_CLK_IN,
  input wire logic [7:0] LOC_ADDR_IN,
  input wire logic LOC_WR_IN,
  input wire logic LOC_RD_IN,
  input wire logic [7:0] LOC_WDATA_IN,
  output logic [7:0] LOC_RDATA_OUT,
  output logic LOC_RVALID_OUT,
  input wire logic [7:0] REM_ADDR_IN,
  input wire logic REM_WR_IN,
  input wire logic REM_RD_IN,
  input wire logic [7:0] REM_WDATA_IN,
  output logic [7:0] REM_RDATA_OUT,
  output logic REM_RVALID_OUT,
  input wire logic [7:0] GPIO_IN,
  output logic [7:0] GPIO_OUT,
  output logic [7:0] GPIO_OE_OUT,
  input wire logic LEGACY_LINK_MODE_IN,
  input wire logic PARTNER_OLD_IN,
  input wire logic ISLAND_DISABLE_IN,
  input wire logic SURROUND_EN_IN,
  input wire logic FOUR_CH_AB_IN,
  input wire logic REPEATER_IN,
  input wire logic REGEN_AUDIO_IN,
  input wire logic [3:0] BACK_GPIO_IN,
  input wire logic [3:0] AUDIO_DATA_IN,
  output logic [3:0] FWD_GPIO_OUT,
  output logic [3:0] FWD_GPIO_EN_OUT,
  output logic REMOTE_MODE_18_OUT,
  output logic [3:0] AUDIO_LANE_OUT,
  output logic [3:0] AUDIO_LANE_EN_OUT,
  output logic AUDIO_ISLAND_OUT,
  output logic AUDIO_SRC_PINS_OUT,
  output logic SURROUND_DOWNSTREAM_OUT
);

  // ==========================================================
  // register storage and access ports
  logic [7:0] cfg [0:sgac_pkg::CFG_COUNT-1];
  logic mode_18;
  logic [7:0] pin_level;
  logic [7:0] back_level;
  logic [7:0] levels_low;
  logic [7:0] levels_high;
  logic loc_hit;
  logic rem_hit;
  logic [7:0] loc_idx;
  logic [7:0] rem_idx;

  assign loc_idx = LOC_ADDR_IN - sgac_pkg::PIN0_CONFIG_ADDR;
  assign rem_idx = REM_ADDR_IN - sgac_pkg::PIN0_CONFIG_ADDR;
  assign loc_hit = (LOC_ADDR_IN >= sgac_pkg::PIN0_CONFIG_ADDR) &&
                   (LOC_ADDR_IN <= sgac_pkg::PIN8_CONFIG_ADDR);
  assign rem_hit = (REM_ADDR_IN >= sgac_pkg::PIN0_CONFIG_ADDR) &&
                   (REM_ADDR_IN <= sgac_pkg::PIN8_CONFIG_ADDR);

  // level readback, bit 4 of the low byte has no pin
  assign levels_low = {pin_level[6:4], 1'b0, pin_level[3:0]};
  assign levels_high = {7'h00, pin_level[7]};

  // both ports write; on a same-address clash the local write lands last
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      for (int k = 0; k < sgac_pkg::CFG_COUNT; k++) begin
        cfg[k] <= sgac_pkg::CFG_RESET;
      end
    end else begin
      if (REM_WR_IN && rem_hit) begin
        cfg[rem_idx[2:0]] <= REM_WDATA_IN;
      end
      if (LOC_WR_IN && loc_hit) begin
        cfg[loc_idx[2:0]] <= LOC_WDATA_IN;
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      mode_18 <= sgac_pkg::MODE_18_RESET;
    end else if (LOC_WR_IN && LOC_ADDR_IN == sgac_pkg::VIDEO_MODE_ADDR) begin
      mode_18 <= LOC_WDATA_IN[sgac_pkg::MODE_18_BIT];
    end else if (REM_WR_IN && REM_ADDR_IN == sgac_pkg::VIDEO_MODE_ADDR) begin
      mode_18 <= REM_WDATA_IN[sgac_pkg::MODE_18_BIT];
    end
  end

  function automatic logic [7:0] read_reg(input logic [7:0] addr, input logic hit,
                                          input logic [2:0] idx, input logic [7:0] c0,
                                          input logic [7:0] c1, input logic [7:0] c2,
                                          input logic [7:0] c3, input logic [7:0] c4,
                                          input logic m18, input logic [7:0] lo,
                                          input logic [7:0] hi);
    logic [7:0] r;
    r = 8'h00;
    if (hit) begin
      unique case (idx)
        3'h0: r = c0;
        3'h1: r = c1;
        3'h2: r = c2;
        3'h3: r = c3;
        default: r = c4;
      endcase
    end else if (addr == sgac_pkg::VIDEO_MODE_ADDR) begin
      r = 8'h00;
      r[sgac_pkg::MODE_18_BIT] = m18;
    end else if (addr == sgac_pkg::PIN_INPUT_LEVELS_LOW_ADDR) begin
      r = lo;
    end else if (addr == sgac_pkg::PIN_INPUT_LEVELS_HIGH_ADDR) begin
      r = hi;
    end
    return r;
  endfunction

  // unmapped addresses read as zero; answer one cycle after the strobe
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      LOC_RDATA_OUT <= 8'h00;
      LOC_RVALID_OUT <= 1'b0;
      REM_RDATA_OUT <= 8'h00;
      REM_RVALID_OUT <= 1'b0;
    end else begin
      LOC_RVALID_OUT <= LOC_RD_IN;
      REM_RVALID_OUT <= REM_RD_IN;
      if (LOC_RD_IN) begin
        LOC_RDATA_OUT <= read_reg(LOC_ADDR_IN, loc_hit, loc_idx[2:0], cfg[0], cfg[1],
                                  cfg[2], cfg[3], cfg[4], mode_18, levels_low,
                                  levels_high);
      end
      if (REM_RD_IN) begin
        REM_RDATA_OUT <= read_reg(REM_ADDR_IN, rem_hit, rem_idx[2:0], cfg[0], cfg[1],
                                  cfg[2], cfg[3], cfg[4], mode_18, levels_low,
                                  levels_high);
      end
    end
  end

  // ==========================================================
  // pin synchronisers and per-pin drive
  // nibble order: link pins 0-3, then register-only pins 5-8
  logic [3:0] nib [0:sgac_pkg::ALL_PINS-1];
  logic legacy;
  logic [2:0] legacy_sync;

  assign nib[0] = cfg[0][3:0];
  assign nib[1] = cfg[1][3:0];
  assign nib[2] = cfg[1][7:4];
  assign nib[3] = cfg[2][3:0];
  assign nib[4] = cfg[2][7:4];
  assign nib[5] = cfg[3][3:0];
  assign nib[6] = cfg[3][7:4];
  assign nib[7] = cfg[4][3:0];

  // a pin change counts once the second and third stages agree
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      legacy_sync <= 3'h0;
      legacy <= 1'b0;
    end else begin
      legacy_sync <= {legacy_sync[1:0], LEGACY_LINK_MODE_IN};
      if (legacy_sync[1] == legacy_sync[2]) begin
        legacy <= legacy_sync[2];
      end
    end
  end

  genvar i;
  generate
    for (i = 0; i < sgac_pkg::ALL_PINS; i++) begin : g_pin
      logic [2:0] sync;
      always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
          sync <= 3'h0;
          pin_level[i] <= 1'b0;
        end else begin
          sync <= {sync[1:0], GPIO_IN[i]};
          if (sync[1] == sync[2]) begin
            pin_level[i] <= sync[2];
          end
        end
      end
      always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
          GPIO_OUT[i] <= 1'b0;
          GPIO_OE_OUT[i] <= 1'b0;
        end else begin
          unique case (nib[i])
            sgac_pkg::CODE_DRIVE_LOW: begin
              GPIO_OUT[i] <= 1'b0;
              GPIO_OE_OUT[i] <= 1'b1;
            end
            sgac_pkg::CODE_DRIVE_HIGH: begin
              GPIO_OUT[i] <= 1'b1;
              GPIO_OE_OUT[i] <= 1'b1;
            end
            sgac_pkg::CODE_BACK_OUT: begin
              // only link pins carry a back-channel level; legacy mode has none
              GPIO_OUT[i] <= back_level[i];
              GPIO_OE_OUT[i] <= (i < sgac_pkg::LINK_PINS) && !legacy;
            end
            default: begin
              GPIO_OUT[i] <= 1'b0;
              GPIO_OE_OUT[i] <= 1'b0;
            end
          endcase
        end
      end
    end
  endgenerate

  // ==========================================================
  // audio lane selection
  logic island;
  logic surround;
  logic [3:0] lanes;
  logic [3:0] lane_gate;

  assign island = !ISLAND_DISABLE_IN;
  assign surround = SURROUND_EN_IN && island && !PARTNER_OLD_IN;

  always_comb begin
    if (legacy) begin
      lanes = sgac_pkg::LANES_NONE;
    end else if (PARTNER_OLD_IN) begin
      lanes = mode_18 ? sgac_pkg::LANES_AB : sgac_pkg::LANES_A;
    end else if (!island) begin
      lanes = sgac_pkg::LANES_A;
    end else if (surround) begin
      lanes = sgac_pkg::LANES_ABCD;
    end else if (FOUR_CH_AB_IN) begin
      lanes = sgac_pkg::LANES_AB;
    end else begin
      lanes = sgac_pkg::LANES_A;
    end
  end

  // an enabled pin function wins over the audio input that shares the pin
  always_comb begin
    lane_gate = lanes;
    if (nib[2] != 4'h0) begin
      lane_gate[2] = 1'b0;
    end
    if (nib[3] != 4'h0) begin
      lane_gate[3] = 1'b0;
    end
    if (nib[sgac_pkg::SHARED_REG_PIN] != 4'h0) begin
      lane_gate[sgac_pkg::SHARED_REG_LANE] = 1'b0;
    end
  end

  // ==========================================================
  // system to link crossing: static levels through two flip-flops each
  localparam int XW = 16;
  logic [XW-1:0] to_link;
  logic [XW-1:0] link_s1;
  logic [XW-1:0] link_s2;
  logic [3:0] fwd_sel;

  generate
    for (i = 0; i < sgac_pkg::LINK_PINS; i++) begin : g_fwd
      // only link pins 0-3 ever reach the far end
      assign fwd_sel[i] = (nib[i] == sgac_pkg::CODE_INPUT) && !legacy;
    end
  endgenerate

  assign to_link = {REPEATER_IN && REGEN_AUDIO_IN,
                    REPEATER_IN && surround,
                    island && !legacy, mode_18 && !legacy,
                    lane_gate, fwd_sel, pin_level[3:0]};

  always_ff @(posedge LINK_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      link_s1 <= '0;
      link_s2 <= '0;
    end else begin
      link_s1 <= to_link;
      link_s2 <= link_s1;
    end
  end

  // ==========================================================
  // link-side logic
  logic [2:0] aud_sync [0:sgac_pkg::AUDIO_LANES-1];
  logic [3:0] aud_level;

  generate
    for (i = 0; i < sgac_pkg::AUDIO_LANES; i++) begin : g_aud
      always_ff @(posedge LINK_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
          aud_sync[i] <= 3'h0;
          aud_level[i] <= 1'b0;
        end else begin
          aud_sync[i] <= {aud_sync[i][1:0], AUDIO_DATA_IN[i]};
          if (aud_sync[i][1] == aud_sync[i][2]) begin
            aud_level[i] <= aud_sync[i][2];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge LINK_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      FWD_GPIO_OUT <= 4'h0;
      FWD_GPIO_EN_OUT <= 4'h0;
      REMOTE_MODE_18_OUT <= 1'b0;
      AUDIO_LANE_OUT <= 4'h0;
      AUDIO_LANE_EN_OUT <= 4'h0;
      AUDIO_ISLAND_OUT <= 1'b0;
      AUDIO_SRC_PINS_OUT <= 1'b0;
      SURROUND_DOWNSTREAM_OUT <= 1'b0;
    end else begin
      FWD_GPIO_EN_OUT <= link_s2[7:4];
      FWD_GPIO_OUT <= link_s2[3:0] & link_s2[7:4];
      AUDIO_LANE_EN_OUT <= link_s2[11:8];
      AUDIO_LANE_OUT <= aud_level & link_s2[11:8];
      REMOTE_MODE_18_OUT <= link_s2[12];
      AUDIO_ISLAND_OUT <= link_s2[13];
      SURROUND_DOWNSTREAM_OUT <= link_s2[14];
      AUDIO_SRC_PINS_OUT <= link_s2[15];
    end
  end

  // ==========================================================
  // back-channel levels into the system domain
  // three stages per bit; a bit moves only once the second and third agree
  logic [11:0] back_sync;
  logic [3:0] back_hold;

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      back_sync <= 12'h000;
      back_hold <= 4'h0;
    end else begin
      back_sync <= {back_sync[7:0], BACK_GPIO_IN};
      back_hold <= (back_sync[7:4] & back_sync[11:8]) |
                   (back_hold & (back_sync[7:4] | back_sync[11:8]));
    end
  end

  assign back_level = {4'h0, back_hold};

endmodule // sgac_top

//--- design/sgac_pkg.sv
// constants for the serializer side-channel pin and audio input block
package sgac_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] PIN0_CONFIG_ADDR = 8'h0D;
  localparam logic [7:0] PIN1_PIN2_CONFIG_ADDR = 8'h0E;
  localparam logic [7:0] PIN3_PIN5_CONFIG_ADDR = 8'h0F;
  localparam logic [7:0] PIN6_PIN7_CONFIG_ADDR = 8'h10;
  localparam logic [7:0] PIN8_CONFIG_ADDR = 8'h11;
  localparam logic [7:0] VIDEO_MODE_ADDR = 8'h12;
  localparam logic [7:0] PIN_INPUT_LEVELS_LOW_ADDR = 8'h1C;
  localparam logic [7:0] PIN_INPUT_LEVELS_HIGH_ADDR = 8'h1D;
  // ==========================================================
  // field layout and reset values
  localparam int CFG_COUNT = 5;
  localparam int MODE_18_BIT = 2;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic MODE_18_RESET = 1'b0;
  // ==========================================================
  // pin configuration nibble codes
  localparam logic [3:0] CODE_DRIVE_LOW = 4'h1;
  localparam logic [3:0] CODE_INPUT = 4'h3;
  localparam logic [3:0] CODE_BACK_OUT = 4'h5;
  localparam logic [3:0] CODE_DRIVE_HIGH = 4'h9;
  // ==========================================================
  // pin and lane counts
  localparam int LINK_PINS = 4;
  localparam int ALL_PINS = 8;
  localparam int AUDIO_LANES = 4;
  // ==========================================================
  // audio lane enable masks, bit 0 is input a
  localparam logic [3:0] LANES_NONE = 4'h0;
  localparam logic [3:0] LANES_A = 4'h1;
  localparam logic [3:0] LANES_AB = 4'h3;
  localparam logic [3:0] LANES_ABCD = 4'hF;
  // register-only pin 5 shares audio input b
  localparam int SHARED_REG_PIN = 4;
  localparam int SHARED_REG_LANE = 1;
endpackage

//--- testbench/sgac_chk.sv
// assertion checker for the side-channel pin and audio block
`timescale 1ns/1ps
module sgac_chk (
  input wire logic SYS_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic LINK_CLK_IN,
  input wire logic [7:0] LOC_ADDR_IN,
  input wire logic LOC_WR_IN,
  input wire logic LOC_RD_IN,
  input wire logic [7:0] LOC_WDATA_IN,
  input wire logic [7:0] LOC_RDATA_OUT,
  input wire logic LOC_RVALID_OUT,
  input wire logic [7:0] REM_ADDR_IN,
  input wire logic REM_WR_IN,
  input wire logic REM_RD_IN,
  input wire logic [7:0] REM_WDATA_IN,
  input wire logic REM_RVALID_OUT,
  input wire logic [7:0] GPIO_OUT,
  input wire logic [7:0] GPIO_OE_OUT,
  input wire logic LEGACY_LINK_MODE_IN,
  input wire logic SURROUND_EN_IN,
  input wire logic [3:0] FWD_GPIO_EN_OUT,
  input wire logic REMOTE_MODE_18_OUT,
  input wire logic [3:0] AUDIO_LANE_EN_OUT
);
  // ==========================================================
  // write steps
  sequence pin0_high_wr_s;
    LOC_WR_IN && LOC_ADDR_IN == 8'h0D && LOC_WDATA_IN == 8'h09;
  endsequence
  // a clashing local write wins, so only a lone remote write is judged
  sequence pin8_low_wr_s;
    REM_WR_IN && REM_ADDR_IN == 8'h11 && REM_WDATA_IN == 8'h01
      && !(LOC_WR_IN && LOC_ADDR_IN == 8'h11);
  endsequence
  sequence mode18_wr_s;
    LOC_WR_IN && LOC_ADDR_IN == 8'h12 && LOC_WDATA_IN[2] && !LEGACY_LINK_MODE_IN;
  endsequence
  // ==========================================================
  // assertions
  loc_read_answer_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    LOC_RD_IN |=> LOC_RVALID_OUT) else $error("local read not answered");
  rem_read_answer_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    REM_RD_IN |=> REM_RVALID_OUT) else $error("remote read not answered");
  no_stray_valid_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    LOC_RVALID_OUT |-> $past(LOC_RD_IN)) else $error("local valid without read");
  unmapped_zero_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    LOC_RD_IN && LOC_ADDR_IN == 8'hFF |=> LOC_RDATA_OUT == 8'h00) else $error("unmapped data");
  drive_high_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    pin0_high_wr_s |=> ##1 GPIO_OE_OUT[0] && GPIO_OUT[0]) else $error("pin 0 not high");
  remote_low_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    pin8_low_wr_s |=> ##1 GPIO_OE_OUT[7] && !GPIO_OUT[7]) else $error("pin 8 not low");
  mode_forward_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    mode18_wr_s |-> ##[1:24] REMOTE_MODE_18_OUT) else $error("18-bit mode not sent");
  legacy_quiet_a: assert property (@(posedge LINK_CLK_IN) disable iff (!RESET_N_IN)
    LEGACY_LINK_MODE_IN [*8] |-> FWD_GPIO_EN_OUT == 4'h0 && !REMOTE_MODE_18_OUT
      && AUDIO_LANE_EN_OUT == 4'h0) else $error("legacy mode left traffic on");
  surround_gate_a: assert property (@(posedge LINK_CLK_IN) disable iff (!RESET_N_IN)
    (!SURROUND_EN_IN) [*8] |-> AUDIO_LANE_EN_OUT[3:2] == 2'b00) else $error("lanes c d on");
endmodule // sgac_chk
bind sgac_top sgac_chk u_sgac_chk (.*);

//--- testbench/sgac_far_model.sv
// behavioural model of the remote deserializer at the link
`timescale 1ns/1ps
module sgac_far_model (
  input wire logic link_clk_in,
  input wire logic reset_n_in,
  input wire logic [3:0] fwd_gpio_in,
  input wire logic [3:0] fwd_en_in,
  input wire logic [3:0] back_level_in,
  output logic [3:0] back_gpio_out,
  output logic [3:0] seen_fwd_out
);
  // ==========================================================
  // back channel and forward capture
  // back levels only move after a link edge, as the real receiver would
  always_ff @(posedge link_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      back_gpio_out <= 4'h0;
      seen_fwd_out <= 4'h0;
    end else begin
      back_gpio_out <= back_level_in;
      seen_fwd_out <= fwd_gpio_in & fwd_en_in;
    end
  end
endmodule // sgac_far_model

//--- testbench/test_serializer_gpio_audio_input_ctrl.sv
// self-checking bench for the side-channel pin and audio block
`timescale 1ns/1ps
module test_serializer_gpio_audio_input_ctrl;
  // ==========================================================
  // stimulus and wiring
  logic SYS_CLK_IN = 1'b0, LINK_CLK_IN = 1'b0, RESET_N_IN = 1'b0;
  logic [7:0] LOC_ADDR_IN = 8'h00, REM_ADDR_IN = 8'h00, LOC_WDATA_IN = 8'h00;
  logic [7:0] REM_WDATA_IN = 8'h00, ext_level = 8'h00, GPIO_IN, GPIO_OUT, GPIO_OE_OUT;
  logic [7:0] LOC_RDATA_OUT, REM_RDATA_OUT;
  logic LOC_WR_IN = 1'b0, LOC_RD_IN = 1'b0, REM_WR_IN = 1'b0, REM_RD_IN = 1'b0;
  logic LEGACY_LINK_MODE_IN = 1'b0, PARTNER_OLD_IN = 1'b0, ISLAND_DISABLE_IN = 1'b0;
  logic SURROUND_EN_IN = 1'b0, FOUR_CH_AB_IN = 1'b0, REPEATER_IN = 1'b0, REGEN_AUDIO_IN = 1'b0;
  logic [3:0] AUDIO_DATA_IN = 4'hF, back_level = 4'h0, BACK_GPIO_IN, FWD_GPIO_OUT;
  logic [3:0] FWD_GPIO_EN_OUT, AUDIO_LANE_OUT, AUDIO_LANE_EN_OUT, seen_fwd;
  logic LOC_RVALID_OUT, REM_RVALID_OUT, REMOTE_MODE_18_OUT, AUDIO_ISLAND_OUT;
  logic AUDIO_SRC_PINS_OUT, SURROUND_DOWNSTREAM_OUT;
  int err_total = 0;
  int n_tests = 0;
  // {older, frames, surround, four_ch, mode 18, legacy, expected lanes d..a}
  logic [9:0] lane_case [8] = '{10'b0010001111, 10'b0001000011, 10'b0000000001,
    10'b0110000001, 10'b1010000001, 10'b1000100011, 10'b1100100011, 10'b0010010000};
  // driven pins read back what is driven, the rest the outside level
  assign GPIO_IN = (GPIO_OE_OUT & GPIO_OUT) | (~GPIO_OE_OUT & ext_level);
  always #2 SYS_CLK_IN = ~SYS_CLK_IN;
  initial begin
    #1.3;
    forever #6 LINK_CLK_IN = ~LINK_CLK_IN;
  end
  sgac_top u_sgac_top (.*);
  sgac_far_model u_sgac_far_model (.link_clk_in(LINK_CLK_IN), .reset_n_in(RESET_N_IN),
    .fwd_gpio_in(FWD_GPIO_OUT), .fwd_en_in(FWD_GPIO_EN_OUT), .back_level_in(back_level),
    .back_gpio_out(BACK_GPIO_IN), .seen_fwd_out(seen_fwd));
  // ==========================================================
  // access tasks
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input bit rem, input logic [7:0] a, input logic [7:0] d);
    @(negedge SYS_CLK_IN);
    {REM_WR_IN, LOC_WR_IN} = rem ? 2'b10 : 2'b01;
    {REM_ADDR_IN, LOC_ADDR_IN, REM_WDATA_IN, LOC_WDATA_IN} = {a, a, d, d};
    @(negedge SYS_CLK_IN);
    {REM_WR_IN, LOC_WR_IN} = 2'b00;
  endtask
  task automatic rd(input bit rem, input logic [7:0] a, input logic [7:0] exp);
    int i;
    @(negedge SYS_CLK_IN);
    {REM_RD_IN, LOC_RD_IN} = rem ? 2'b10 : 2'b01;
    {REM_ADDR_IN, LOC_ADDR_IN} = {a, a};
    @(negedge SYS_CLK_IN);
    {REM_RD_IN, LOC_RD_IN} = 2'b00;
    i = 0;
    while ((rem ? REM_RVALID_OUT : LOC_RVALID_OUT) !== 1'b1 && i < 4) begin
      @(negedge SYS_CLK_IN);
      i++;
    end
    if (i == 4) check("read answer", 8'h01, 8'h00);
    check("read data", exp, rem ? REM_RDATA_OUT : LOC_RDATA_OUT);
  endtask
  // pin syncs and link crossings take a few cycles of either clock
  task automatic settle();
    repeat (30) @(negedge SYS_CLK_IN);
  endtask
  task automatic final_report();
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // tests
  initial begin
    #20000;
    err_total++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge LINK_CLK_IN);
    @(negedge SYS_CLK_IN);
    RESET_N_IN = 1'b1;
    for (int a = 8'h0D; a <= 8'h12; a++) rd(0, a[7:0], 8'h00);
    ext_level = 8'hA5;
    settle();
    rd(0, 8'h1C, {ext_level[6:4], 1'b0, ext_level[3:0]});
    rd(1, 8'h1D, {7'h00, ext_level[7]});
    wr(0, 8'h1C, 8'hFF);
    rd(0, 8'h1C, {ext_level[6:4], 1'b0, ext_level[3:0]});
    rd(0, 8'hFF, 8'h00);
    wr(1, 8'h0E, 8'h93);
    rd(0, 8'h0E, 8'h93);
    wr(0, 8'h0D, 8'h09);
    wr(1, 8'h11, 8'h01);
    wr(0, 8'h10, 8'h19);
    settle();
    check("pin enables", 8'hE5, GPIO_OE_OUT);
    check("pin levels", 8'h25, GPIO_OUT);
    rd(0, 8'h1C, 8'h45);
    rd(1, 8'h1D, 8'h00);
    wr(0, 8'h12, 8'h04);
    wr(0, 8'h0D, 8'h03);
    wr(0, 8'h0E, 8'h50);
    wr(0, 8'h0F, 8'h33);
    ext_level = 8'hFF;
    back_level = 4'h4;
    settle();
    check("forward enables", 8'h09, {4'h0, FWD_GPIO_EN_OUT});
    check("forward levels", 8'h09, {4'h0, seen_fwd});
    check("back drive", 8'h03, {6'h00, GPIO_OE_OUT[2], GPIO_OUT[2]});
    check("remote mode", 8'h01, {7'h00, REMOTE_MODE_18_OUT});
    wr(0, 8'h0E, 8'h00);
    wr(0, 8'h0F, 8'h00);
    foreach (lane_case[k]) begin
      {PARTNER_OLD_IN, ISLAND_DISABLE_IN, SURROUND_EN_IN, FOUR_CH_AB_IN} = lane_case[k][9:6];
      LEGACY_LINK_MODE_IN = lane_case[k][4];
      // a different data pattern per case shows that each lane carries its own line
      AUDIO_DATA_IN = k[3:0] ^ 4'hA;
      wr(0, 8'h12, {5'h00, lane_case[k][5], 2'h0});
      settle();
      check("lane enables", {4'h0, lane_case[k][3:0]},
        {4'h0, AUDIO_LANE_EN_OUT});
      check("lane data", {4'h0, lane_case[k][3:0] & AUDIO_DATA_IN},
        {4'h0, AUDIO_LANE_OUT});
      check("packet mode", {7'h00, !lane_case[k][8] && !lane_case[k][4]},
        {7'h00, AUDIO_ISLAND_OUT});
    end
    {LEGACY_LINK_MODE_IN, PARTNER_OLD_IN, ISLAND_DISABLE_IN} = 3'b000;
    {SURROUND_EN_IN, REPEATER_IN, REGEN_AUDIO_IN} = 3'b111;
    wr(0, 8'h0E, 8'h10);
    wr(1, 8'h0F, 8'h30);
    settle();
    check("shared pins", 8'h09, {4'h0, AUDIO_LANE_EN_OUT});
    check("regenerate", 8'h01, {7'h00, AUDIO_SRC_PINS_OUT});
    check("surround down", 8'h01, {7'h00, SURROUND_DOWNSTREAM_OUT});
    final_report();
  end
endmodule // test_serializer_gpio_audio_input_ctrl
